// ---- gyro_filter_regs.svh ----
// Purpose: timing counts, settling-sample counts and field codes for the
//          gyroscope filter chain control block
// Assumes: 40 MHz system clock (25 ns period)
// Notes:   every timing count is a time divided by the clock period
`ifndef GYRO_FILTER_REGS_SVH
`define GYRO_FILTER_REGS_SVH

`define CLK_PERIOD_NS        25
`define WAKE_TIME_MS         70
`define WAKE_CYCLES          ((`WAKE_TIME_MS * 1000000) / `CLK_PERIOD_NS)
`define PD_FAST_TIME_US      1
`define PD_FAST_CYCLES       ((`PD_FAST_TIME_US * 1000) / `CLK_PERIOD_NS)
`define PD_SLOW_TIME_US      300
`define PD_SLOW_CYCLES       ((`PD_SLOW_TIME_US * 1000) / `CLK_PERIOD_NS)

`define DISCARD_ONE          4'h1
`define DISCARD_TWO          4'h2
`define HP_EXTRA_SAMPLES     4'h0

`define ODR_12HZ5            4'h1
`define ODR_26HZ             4'h2
`define ODR_52HZ             4'h3
`define ODR_104HZ            4'h4
`define ODR_208HZ            4'h5
`define ODR_417HZ            4'h6
`define ODR_833HZ            4'h7
`define ODR_1K66             4'h8
`define ODR_3K33             4'h9
`define ODR_6K66             4'hA

`define AUX_MODE_3           2'h2
`define AUX_MODE_4           2'h3

`endif

// ---- gyro_filter_pkg.sv ----
// Purpose: types for the gyroscope filter chain control block
// Assumes: nothing beyond the constants header
// Notes:   power modes are a plain two-bit code from the host
package gyro_filter_pkg;

  typedef enum logic [1:0] {
    PWR_DOWN   = 2'h0,
    PWR_SLEEP  = 2'h1,
    PWR_LPNORM = 2'h2,
    PWR_HIPERF = 2'h3
  } power_mode_t;

  typedef struct packed {
    logic       lowpass1_select;
    logic [2:0] lowpass1_bandwidth_field;
    logic       ui_highpass_enable;
    logic       stab_highpass_enable;
    logic [1:0] highpass_cutoff_code;
  } filter_cfg_t;

  typedef struct packed {
    logic       lp1_on_user;
    logic       lp1_on_stab;
    logic [2:0] lp1_bw;
    logic       lp2_bypass;
    logic       hp_on_user;
    logic       hp_on_stab;
    logic [1:0] hp_cutoff;
    logic       cfg_unsupported;
  } chain_route_t;

  typedef enum logic [3:0] {
    SEQ_OFF    = 4'h1,
    SEQ_WAKE   = 4'h2,
    SEQ_RUN    = 4'h4,
    SEQ_PDWAIT = 4'h8
  } pwr_state_t;

endpackage

// ---- gyro_filter_chain_control.sv ----
// Purpose: routes the gyro low-pass and high-pass stages for the user and
//          stabilization chains and marks settling samples invalid
// Assumes: sample_tick_in is a one-cycle pulse at the user output rate,
//          made on clk_in; config inputs come from registers on clk_in
// Notes:   one clock; every output registered
// Functional notes
// RULE_01 - first low-pass used only when select is 1; bandwidth from field
// RULE_02 - second low-pass follows rate, bypassed at 6.66 kHz
// RULE_03 - at 3333/6667 Hz with first low-pass on, codes 1xx unsupported
// RULE_04 - modes 3 and 4 give a user chain at any selectable rate
// RULE_05 - modes 3 and 4 give stabilization data at fixed 6.66 kHz
// RULE_06 - modes 3 and 4: first low-pass serves stabilization chain only
// RULE_07 - user high-pass enable wins the shared filter for user chain
// RULE_08 - else stabilization enable takes it; never both chains at once
// RULE_09 - software should not use first low-pass if modes 3/4 intended
// RULE_10 - power-mode change takes effect at end of current sample period
// RULE_11 - power-down exit takes 70 ms; low-power/normal discards one sample
// RULE_12 - power-down to high-performance: 70 ms plus settling samples
// RULE_13 - rate change in low-power/normal, or sleep exit, discards one
// RULE_14 - to high-perf two, high-perf rate change two, leaving it one
// RULE_15 - power-down within 1 us, or 300 us with accelerometer active
// RULE_16 - high-pass enabled by user enable, cutoff from two-bit code; outside modes 3 and 4 code also requires high-perf mode
// RULE_17 - high-pass settling added on entering high-perf with it enabled; code adds HP_EXTRA_SAMPLES, which is 0
// RULE_18 - discard counter loaded at each change, samples invalid until zero
`timescale 1ns/1ps
`include "gyro_filter_regs.svh"
`default_nettype none

module gyro_filter_chain_control
  import gyro_filter_pkg::*;
#(
  parameter int unsigned WAKE_CYCLES = `WAKE_CYCLES
) (
  input  wire logic         clk_in,
  input  wire logic         nrst_in,
  input  wire logic         sample_tick_in,
  input  wire logic         stab_tick_in,
  input  wire logic [1:0]   power_mode_in,
  input  wire logic [3:0]   odr_code_in,
  input  wire logic [1:0]   aux_mode_in,
  input  wire logic         accel_sensor_active_in,
  input  wire filter_cfg_t  cfg_in,
  output var chain_route_t  route_out,
  output logic [3:0]        user_odr_out,
  output logic              stab_sample_out,
  output logic [1:0]        power_mode_out,
  output logic              powered_out,
  output logic              sample_valid_out,
  output logic [3:0]        discard_left_out
);

  localparam int unsigned PD_FAST = `PD_FAST_CYCLES;
  localparam int unsigned PD_SLOW = `PD_SLOW_CYCLES;

  // ---------------------------------------------------------------
  // filter routing
  // ---------------------------------------------------------------
  chain_route_t route_next;
  logic         aux_mode;
  logic         fast_odr;

  always_comb begin
    aux_mode = (aux_mode_in == `AUX_MODE_3) || (aux_mode_in == `AUX_MODE_4);
    // judged on the active rate, not on a request still waiting for a tick
    fast_odr = (user_odr_out == `ODR_3K33) || (user_odr_out == `ODR_6K66);
    route_next = '0;
    route_next.lp1_bw = cfg_in.lowpass1_bandwidth_field; // [RULE_01]
    // in aux modes the first stage belongs to the stabilization chain
    route_next.lp1_on_user = cfg_in.lowpass1_select &&
                             !aux_mode; // [RULE_01] [RULE_06]
    route_next.lp1_on_stab = cfg_in.lowpass1_select && aux_mode; // [RULE_06]
    route_next.lp2_bypass = (power_mode_out != PWR_DOWN) &&
                            (user_odr_out == `ODR_6K66); // [RULE_02]
    route_next.cfg_unsupported = route_next.lp1_on_user && fast_odr &&
                                 cfg_in.lowpass1_bandwidth_field[2]; // [RULE_03]
    route_next.hp_cutoff = cfg_in.highpass_cutoff_code; // [RULE_16]
    if (aux_mode) begin
      route_next.hp_on_user = cfg_in.ui_highpass_enable; // [RULE_07]
      route_next.hp_on_stab = !cfg_in.ui_highpass_enable &&
                              cfg_in.stab_highpass_enable; // [RULE_08]
    end else begin
      route_next.hp_on_user = cfg_in.ui_highpass_enable &&
                              (power_mode_out == PWR_HIPERF); // [RULE_16]
      route_next.hp_on_stab = 1'b0;
    end
  end

  // stabilization chain runs at its own fixed-rate tick in aux modes only
  logic stab_sample_next;
  always_comb begin
    stab_sample_next = aux_mode && stab_tick_in && powered_out; // [RULE_05]
  end

  always_ff @(posedge clk_in) begin
    if (!nrst_in) begin
      route_out       <= '0;
      stab_sample_out <= 1'b0;
    end else begin
      route_out       <= route_next;
      stab_sample_out <= stab_sample_next;
    end
  end

  // ---------------------------------------------------------------
  // power sequencing and settling discard
  // ---------------------------------------------------------------
  pwr_state_t  state_reg, state_next;
  logic [31:0] timer_reg, timer_next;
  logic [1:0]  mode_reg, mode_next;
  logic [3:0]  odr_reg, odr_next;
  logic [3:0]  disc_reg, disc_next;
  logic        powered_next;
  logic        valid_next;
  logic        hp_prev_reg, hp_prev_next;
  logic [1:0]  req_mode;
  logic [3:0]  load;

  // samples to throw away for a move from one running setting to another
  function automatic logic [3:0] settle_count(input logic [1:0] from_m,
                                              input logic [1:0] to_m,
                                              input logic       hp_on);
    logic [3:0] n;
    n = `DISCARD_ONE;
    if (to_m == PWR_HIPERF) begin
      n = `DISCARD_TWO; // [RULE_14] [RULE_12]
      if (hp_on) begin
        n = n + `HP_EXTRA_SAMPLES; // [RULE_17]
      end
    end else if (from_m == PWR_HIPERF) begin
      n = `DISCARD_ONE; // [RULE_14]
    end
    return n;
  endfunction

  always_comb begin
    req_mode     = power_mode_in;
    state_next   = state_reg;
    timer_next   = timer_reg;
    mode_next    = mode_reg;
    odr_next     = odr_reg;
    disc_next    = disc_reg;
    powered_next = powered_out;
    // enable edge judged at the sample boundary so a mid-period rise counts
    hp_prev_next = (state_reg == SEQ_RUN && !sample_tick_in) ?
                   hp_prev_reg : cfg_in.ui_highpass_enable;
    load         = 4'h0;
    unique case (state_reg)
      SEQ_OFF: begin
        if (req_mode != PWR_DOWN) begin
          state_next = SEQ_WAKE; // [RULE_11]
          timer_next = WAKE_CYCLES;
          mode_next  = req_mode;
          odr_next   = odr_code_in;
        end
      end
      SEQ_WAKE: begin
        if (timer_reg <= 32'h1) begin
          state_next   = SEQ_RUN;
          powered_next = 1'b1;
          if (mode_reg == PWR_SLEEP) begin
            disc_next = 4'h0; // [RULE_11]
          end else begin
            disc_next = settle_count(PWR_DOWN, mode_reg, // [RULE_11] [RULE_12]
                                     cfg_in.ui_highpass_enable);
          end
        end else begin
          timer_next = timer_reg - 32'h1;
        end
      end
      SEQ_RUN: begin
        // changes wait for the sample boundary so output timing holds
        if (sample_tick_in) begin // [RULE_10]
          if (disc_reg != 4'h0) begin
            disc_next = disc_reg - 4'h1; // [RULE_18]
          end
          if (req_mode == PWR_DOWN) begin
            state_next   = SEQ_PDWAIT; // [RULE_15]
            timer_next   = accel_sensor_active_in ? PD_SLOW : PD_FAST;
            powered_next = 1'b0;
            disc_next    = 4'h0;
          end else if (req_mode != mode_reg || odr_code_in != odr_reg) begin
            mode_next = req_mode;
            odr_next  = odr_code_in;
            if (req_mode == PWR_SLEEP) begin
              load = 4'h0;
            end else if (mode_reg == PWR_SLEEP) begin
              load = (req_mode == PWR_HIPERF) ?
                     settle_count(PWR_DOWN, req_mode,
                                  cfg_in.ui_highpass_enable) :
                     `DISCARD_ONE; // [RULE_13]
            end else begin
              load = settle_count(mode_reg, req_mode,
                                  cfg_in.ui_highpass_enable); // [RULE_13] [RULE_14]
            end
            disc_next = load; // [RULE_18]
          end else if (cfg_in.ui_highpass_enable && !hp_prev_reg &&
                       mode_reg == PWR_HIPERF) begin
            disc_next = disc_reg + `HP_EXTRA_SAMPLES; // [RULE_17]
          end
        end
      end
      SEQ_PDWAIT: begin
        if (timer_reg <= 32'h1) begin
          state_next = SEQ_OFF; // [RULE_15]
          mode_next  = PWR_DOWN;
        end else begin
          timer_next = timer_reg - 32'h1;
        end
      end
      default: begin
        state_next = SEQ_OFF;
      end
    endcase
    valid_next = powered_next && (mode_next != PWR_SLEEP) &&
                 (disc_next == 4'h0); // [RULE_18]
  end

  always_ff @(posedge clk_in) begin
    if (!nrst_in) begin
      state_reg        <= SEQ_OFF;
      timer_reg        <= 32'h0;
      mode_reg         <= PWR_DOWN;
      odr_reg          <= 4'h0;
      disc_reg         <= 4'h0;
      hp_prev_reg      <= 1'b0;
      powered_out      <= 1'b0;
      sample_valid_out <= 1'b0;
    end else begin
      state_reg        <= state_next;
      timer_reg        <= timer_next;
      mode_reg         <= mode_next;
      odr_reg          <= odr_next;
      disc_reg         <= disc_next;
      hp_prev_reg      <= hp_prev_next;
      powered_out      <= powered_next;
      sample_valid_out <= valid_next;
    end
  end

  always_ff @(posedge clk_in) begin
    if (!nrst_in) begin
      power_mode_out   <= 2'h0;
      user_odr_out     <= 4'h0;
      discard_left_out <= 4'h0;
    end else begin
      power_mode_out   <= mode_next;
      user_odr_out     <= odr_next; // [RULE_04]
      discard_left_out <= disc_next;
    end
  end

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  property p_hp_exclusive;
    @(posedge clk_in) disable iff (!nrst_in)
      !(route_out.hp_on_user && route_out.hp_on_stab);
  endproperty
  a_hp_exclusive: assert property (p_hp_exclusive) // [RULE_08]
    else $error("high-pass on both chains");

  property p_hp_user_wins;
    @(posedge clk_in) disable iff (!nrst_in)
      (aux_mode && cfg_in.ui_highpass_enable) |=> route_out.hp_on_user;
  endproperty
  a_hp_user_wins: assert property (p_hp_user_wins) // [RULE_07]
    else $error("user high-pass not granted");

  property p_hp_stab;
    @(posedge clk_in) disable iff (!nrst_in)
      (aux_mode && !cfg_in.ui_highpass_enable && cfg_in.stab_highpass_enable)
      |=> route_out.hp_on_stab;
  endproperty
  a_hp_stab: assert property (p_hp_stab) // [RULE_08]
    else $error("stab high-pass not granted");

  property p_lp1_aux;
    @(posedge clk_in) disable iff (!nrst_in)
      aux_mode |=> !route_out.lp1_on_user;
  endproperty
  a_lp1_aux: assert property (p_lp1_aux) // [RULE_06]
    else $error("first low-pass on user chain in aux mode");

  property p_lp1_sel;
    @(posedge clk_in) disable iff (!nrst_in)
      (!cfg_in.lowpass1_select) |=> !(route_out.lp1_on_user ||
                                      route_out.lp1_on_stab);
  endproperty
  a_lp1_sel: assert property (p_lp1_sel) // [RULE_01]
    else $error("first low-pass inserted while deselected");

  property p_unsup;
    @(posedge clk_in) disable iff (!nrst_in)
      (cfg_in.lowpass1_select && !aux_mode && fast_odr &&
       cfg_in.lowpass1_bandwidth_field[2]) |=> route_out.cfg_unsupported;
  endproperty
  a_unsup: assert property (p_unsup) // [RULE_03]
    else $error("unsupported code not flagged");

  sequence s_wake_start;
    state_reg == SEQ_OFF && power_mode_in != PWR_DOWN;
  endsequence
  property p_wake_hold;
    @(posedge clk_in) disable iff (!nrst_in)
      s_wake_start |=> !powered_out [*8];
  endproperty
  a_wake_hold: assert property (p_wake_hold) // [RULE_11]
    else $error("powered before wake time");

  property p_discard_invalid;
    @(posedge clk_in) disable iff (!nrst_in)
      (discard_left_out != 4'h0) |-> !sample_valid_out;
  endproperty
  a_discard_invalid: assert property (p_discard_invalid) // [RULE_18]
    else $error("valid during discard");

  property p_no_mid_change;
    @(posedge clk_in) disable iff (!nrst_in)
      (state_reg == SEQ_RUN && !sample_tick_in) |=> $stable(power_mode_out);
  endproperty
  a_no_mid_change: assert property (p_no_mid_change) // [RULE_10]
    else $error("mode changed mid period");

endmodule

`default_nettype wire

// ---- stab_tick_src.sv ----
// Purpose: stand-in for the fixed-rate stabilization sample timebase
// Assumes: shares clk_in with the block under test
// Notes:   divide ratio scaled down (rate raised) so the run stays short; pulse shape kept
`timescale 1ns/1ps
`default_nettype none
module stab_tick_src #(
  parameter int DIV = 6
) (
  input  wire logic clk_in,
  input  wire logic nrst_in,
  output logic      tick_out
);
  int cnt_reg;
  // ----------------------------------------
  // one-cycle pulse every DIV cycles
  // ----------------------------------------
  always_ff @(posedge clk_in) begin
    if (!nrst_in) begin
      cnt_reg  <= 0;
      tick_out <= 1'b0;
    end else begin
      cnt_reg  <= (cnt_reg == DIV - 1) ? 0 : cnt_reg + 1;
      tick_out <= (cnt_reg == DIV - 1);
    end
  end
endmodule
`default_nettype wire

// ---- gyro_filter_chain_control_test.sv ----
// Purpose: self-checking bench for the gyro filter chain control
// Assumes: short wake count; sample ticks driven by hand for exact timing
// Notes:   routing checked only where the active rate equals the request
`timescale 1ns/1ps
`include "gyro_filter_regs.svh"
`default_nettype none
module gyro_filter_chain_control_test;
  import gyro_filter_pkg::*;
  localparam int WAKE = 20;
  logic clk_in = 1'b0, nrst_in = 1'b0, sample_tick_in = 1'b0;
  logic stab_tick_in;
  logic [1:0] power_mode_in = 2'h0, aux_mode_in = 2'h0;
  logic [3:0] odr_code_in = `ODR_104HZ;
  logic accel_sensor_active_in = 1'b0;
  filter_cfg_t cfg_in = '0;
  chain_route_t route_out;
  logic [3:0] user_odr_out, discard_left_out;
  logic [1:0] power_mode_out;
  logic stab_sample_out, powered_out, sample_valid_out;
  int failures = 0, num_checks = 0, cycles = 0, n;
  filter_cfg_t cfgs [4] = '{8'h00, 8'hB6, 8'h0D, 8'hD3};
  logic [3:0] odrs [3] = '{`ODR_1K66, `ODR_3K33, `ODR_6K66};

  always #12.5 clk_in = ~clk_in;

  gyro_filter_chain_control #(.WAKE_CYCLES(WAKE)) dut (
    .clk_in(clk_in), .nrst_in(nrst_in), .sample_tick_in(sample_tick_in),
    .stab_tick_in(stab_tick_in), .power_mode_in(power_mode_in),
    .odr_code_in(odr_code_in), .aux_mode_in(aux_mode_in),
    .accel_sensor_active_in(accel_sensor_active_in), .cfg_in(cfg_in),
    .route_out(route_out), .user_odr_out(user_odr_out),
    .stab_sample_out(stab_sample_out), .power_mode_out(power_mode_out),
    .powered_out(powered_out), .sample_valid_out(sample_valid_out),
    .discard_left_out(discard_left_out));

  stab_tick_src stab (.clk_in(clk_in), .nrst_in(nrst_in),
    .tick_out(stab_tick_in));

  // ----------------------------------------
  // compare and closing
  // ----------------------------------------
  task automatic test_done();
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  task automatic chk_bit(string what, logic e, logic g);
    num_checks++;
    if (g !== e) begin
      failures++;
      $display("FAIL %s exp %b got %b", what, e, g);
    end
  endtask

  task automatic chk_vec(string what, logic [3:0] e, logic [3:0] g);
    num_checks++;
    if (g !== e) begin
      failures++;
      $display("FAIL %s exp %h got %h", what, e, g);
    end
  endtask

  task automatic chk_route(chain_route_t e, chain_route_t g);
    num_checks++;
    if (g !== e) begin
      failures++;
      $display("FAIL route exp %b got %b", e, g);
    end
  endtask

  always @(posedge clk_in) begin
    cycles++;
    // worst path is one slow power-down plus a few hundred cycles
    if (cycles == 40000) begin
      failures++;
      test_done();
    end
  end

  function automatic chain_route_t exp_route(logic [1:0] a,
                                             filter_cfg_t c, logic [3:0] o);
    chain_route_t e;
    logic x;
    x = (a == `AUX_MODE_3) || (a == `AUX_MODE_4);
    e.lp1_on_user = c.lowpass1_select & ~x;
    e.lp1_on_stab = c.lowpass1_select & x;
    e.lp1_bw = c.lowpass1_bandwidth_field;
    e.lp2_bypass = (o == `ODR_6K66);
    e.hp_on_user = c.ui_highpass_enable;
    e.hp_on_stab = x & ~c.ui_highpass_enable
      & c.stab_highpass_enable;
    e.hp_cutoff = c.highpass_cutoff_code;
    e.cfg_unsupported = c.lowpass1_select & c.lowpass1_bandwidth_field[2]
      & ~x & (o == `ODR_3K33 || o == `ODR_6K66);
    return e;
  endfunction

  // ----------------------------------------
  // stimulus helpers
  // ----------------------------------------
  task automatic tick();
    @(posedge clk_in);
    sample_tick_in <= 1'b1;
    @(posedge clk_in);
    sample_tick_in <= 1'b0;
    repeat (2) @(negedge clk_in);
  endtask

  task automatic wait_powered();
    n = 0;
    while (powered_out !== 1'b1 && n < 20000) begin
      @(negedge clk_in);
      n++;
    end
  endtask

  task automatic change(logic [1:0] pm, logic [3:0] o, logic [3:0] d);
    @(posedge clk_in);
    power_mode_in <= pm;
    odr_code_in <= o;
    tick();
    chk_vec("mode", {2'h0, pm}, {2'h0, power_mode_out});
    chk_vec("discard", d, discard_left_out);
    repeat (d) tick();
    chk_bit("valid", 1'b1, sample_valid_out);
  endtask

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic wake_hiperf();
    @(posedge clk_in);
    power_mode_in <= 2'h3;
    wait_powered();
    chk_vec("odr", `ODR_104HZ, user_odr_out);
    chk_vec("discard", `DISCARD_TWO, discard_left_out);
    chk_bit("valid", 1'b0, sample_valid_out);
    tick();
    chk_vec("discard", `DISCARD_ONE, discard_left_out);
    tick();
    chk_bit("valid", 1'b1, sample_valid_out);
  endtask

  task automatic held_rate_change();
    @(posedge clk_in);
    odr_code_in <= `ODR_833HZ;
    repeat (5) @(negedge clk_in);
    chk_vec("odr held", `ODR_104HZ, user_odr_out);
    chk_bit("valid held", 1'b1, sample_valid_out);
    change(2'h3, `ODR_833HZ, `DISCARD_TWO);
  endtask

  task automatic route_table();
    for (int r = 0; r < 3; r++) begin
      change(2'h3, odrs[r], `DISCARD_TWO);
      for (int a = 0; a < 4; a++) begin
        for (int c = 0; c < ((a > 1) ? 3 : 4); c++) begin
          @(posedge clk_in);
          aux_mode_in <= a[1:0];
          // lp1 left off in two of the three aux-mode cases
          cfg_in <= cfgs[c];
          repeat (2) @(negedge clk_in);
          chk_route(exp_route(a[1:0], cfgs[c], odrs[r]), route_out);
          chk_vec("user odr", odrs[r], user_odr_out);
        end
      end
    end
  endtask

  task automatic stab_path(logic [1:0] a, logic e);
    @(posedge clk_in);
    aux_mode_in <= a;
    repeat (2) @(negedge clk_in);
    n = 0;
    while (stab_tick_in !== 1'b1 && n < 20) begin
      @(negedge clk_in);
      n++;
    end
    @(negedge clk_in);
    chk_bit("stab sample", e, stab_sample_out);
  endtask

  task automatic power_walk();
    change(2'h2, `ODR_6K66, `DISCARD_ONE);
    change(2'h2, `ODR_208HZ, `DISCARD_ONE);
    @(posedge clk_in);
    power_mode_in <= 2'h1;
    tick();
    chk_vec("mode", 4'h1, {2'h0, power_mode_out});
    chk_bit("sleep valid", 1'b0, sample_valid_out);
    change(2'h2, `ODR_208HZ, `DISCARD_ONE);
    change(2'h3, `ODR_208HZ, `DISCARD_TWO);
  endtask

  task automatic power_down(logic acc, int pd);
    @(posedge clk_in);
    accel_sensor_active_in <= acc;
    power_mode_in <= 2'h0;
    tick();
    chk_bit("powered", 1'b0, powered_out);
    chk_bit("pd valid", 1'b0, sample_valid_out);
    @(posedge clk_in);
    power_mode_in <= 2'h2;
    wait_powered();
    chk_bit("pd time", 1'b1,
            n >= pd + WAKE - 4 && n <= pd + WAKE + 6);
    chk_vec("discard", `DISCARD_ONE, discard_left_out);
    tick();
    chk_bit("valid", 1'b1, sample_valid_out);
  endtask

  initial begin
    repeat (16) @(posedge clk_in);
    nrst_in <= 1'b1;
    @(negedge clk_in);
    chk_bit("powered", 1'b0, powered_out);
    wake_hiperf();
    held_rate_change();
    route_table();
    stab_path(`AUX_MODE_3, 1'b1);
    stab_path(`AUX_MODE_4, 1'b1);
    stab_path(2'h0, 1'b0);
    @(posedge clk_in);
    cfg_in <= '0;
    power_walk();
    power_down(1'b1, `PD_SLOW_CYCLES);
    power_down(1'b0, `PD_FAST_CYCLES);
    test_done();
  end
endmodule
`default_nettype wire
